// [ccs_map.svh]
// Offsets, reset values, opcodes and register port indices of the core cycle sequencer
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
`define CCS_PORT0_LATCH 8'h80
`define CCS_STACK_POINTER 8'h81
`define CCS_DATA_POINTER_LOW 8'h82
`define CCS_DATA_POINTER_HIGH 8'h83
`define CCS_POWER_CONTROL 8'h87
`define CCS_TIMER_CONTROL 8'h88
`define CCS_TIMER_MODE_SELECT 8'h89
`define CCS_TIMER0_LOW_BYTE 8'h8a
`define CCS_TIMER1_LOW_BYTE 8'h8b
`define CCS_TIMER0_HIGH_BYTE 8'h8c
`define CCS_TIMER1_HIGH_BYTE 8'h8d
`define CCS_PORT1_LATCH 8'h90
`define CCS_PORT1_FUNCTION_SELECT 8'h91
`define CCS_PORT3_FUNCTION_SELECT 8'h93
`define CCS_PORT4_FUNCTION_SELECT 8'h94
`define CCS_ADC_CLOCK_PRESCALER 8'h95
`define CCS_ADC_RESULT 8'h96
`define CCS_ADC_CONTROL_STATUS 8'h97
`define CCS_UART0_CONTROL 8'h98
`define CCS_UART0_BUFFER 8'h99
`define CCS_UART1_CONTROL 8'h9a
`define CCS_UART1_BUFFER 8'h9b
`define CCS_PORT2_LATCH 8'ha0
`define CCS_STATUS_WORD 8'hd0
`define CCS_ACCUMULATOR 8'he0
`define CCS_PORT_RESET 8'hff
`define CCS_STACK_RESET 8'h07
`define CCS_CARRY_BIT 7
`define CCS_BIT_RAM_BASE 7'h20
`define CCS_IDX_CTRL 8'h00
`define CCS_IDX_STATUS 8'h01
`define CCS_IDX_SFR_FIRST 8'h80
`define CCS_OP_NOP 8'h00
`define CCS_OP_SHORT_JUMP 8'h80
`define CCS_OP_ACC_ZERO 8'h60
`define CCS_OP_ACC_NONZERO 8'h70
`define CCS_OP_DEC_DIRECT 8'hd5
`define CCS_OP_DEC_REG_HI 5'b11011
`define CCS_OP_CMP_IMM 8'hb4
`define CCS_OP_LOAD_ACC 8'h74
`define CCS_OP_STORE_DIRECT 8'hf5
`define CCS_OP_SET_BIT 8'hd2
`define CCS_OP_CLEAR_BIT 8'hc2
`define CCS_OP_XMOVE_RD 8'he0
`define CCS_OP_XMOVE_WR 8'hf0
`endif

// [ccs_pkg.sv]
// Types shared by the core cycle sequencer
package ccs_pkg;
   typedef enum logic [2:0] {S1, S2, S3, S4, S5, S6} ccs_slot_t;
   typedef struct packed {
      ccs_slot_t st;
      logic ph;
      logic cyc2;
      logic run;
      logic [7:0] op;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [15:0] pc;
      logic [15:0] memAddr;
      logic [7:0] memDataOut;
      logic memResetN;
      logic apbDone;
      logic [31:0] prdata;
      logic [127:0][7:0] ram;
      logic [127:0][7:0] sfr;
   } ccs_state_t;
endpackage : ccs_pkg

// [ccs_core_sequencer.sv]
// Core fetch/execute sequencer with special function space and APB slave
//
// Functional notes
// - Six states S1..S6 per machine cycle
// - Each state lasts two clocks, twelve total
// - Each state has two one-clock halves
// - Two program fetches per machine cycle, none in data move second
// - Unneeded fetch byte discarded, counter held
// - Opcode latched during state one
// - Second fetch in S4, done end S6
// - Data move: two cycles, no fetch second
// - Fetches skipped only in data move
// - Decrement operand, branch when result nonzero
// - 16-bit address, 8-bit data, memory strobes
// - Unoccupied addresses read arbitrary, writes ignored
// - Row-start registers are bit addressable
// - Signed 8-bit displacement from next instruction
// - No zero flag; accumulator tested directly
// - Compare branch taken only when unequal
// - Unsigned compare sets carry when less
//
// The APB register port was left to the implementer.
`include "ccs_map.svh"
module ccs_core_sequencer #(
   parameter logic RUN_AT_RESET = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] memAddr,
   output logic [7:0] memDataOut,
   input wire logic [7:0] memDataIn,
   output logic memReadN,
   output logic memWriteN,
   output logic progStoreStrobeN,
   output logic addrLatch,
   output logic memResetN
);
   timeunit 1ns;
   timeprecision 1ps;
   ccs_pkg::ccs_state_t cur_ff;
   ccs_pkg::ccs_state_t nxt_cur;
   logic movxCyc;
   logic [7:0] apbIdx;
   logic apbErr;

   function automatic logic isMovx(input logic [7:0] op);
      return (op == `CCS_OP_XMOVE_RD) || (op == `CCS_OP_XMOVE_WR);
   endfunction : isMovx

   // Slot of a special function address in the 128-entry register store
   function automatic logic [6:0] sfrSlot(input logic [7:0] a);
      return a[6:0];
   endfunction : sfrSlot

   function automatic logic [1:0] instLen(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd1;
      if (op[7:3] == `CCS_OP_DEC_REG_HI) begin
         n = 2'd2;
      end else if (op == `CCS_OP_DEC_DIRECT || op == `CCS_OP_CMP_IMM) begin
         n = 2'd3;
      end else if (op == `CCS_OP_SHORT_JUMP || op == `CCS_OP_ACC_ZERO ||
                   op == `CCS_OP_ACC_NONZERO || op == `CCS_OP_LOAD_ACC ||
                   op == `CCS_OP_STORE_DIRECT || op == `CCS_OP_SET_BIT ||
                   op == `CCS_OP_CLEAR_BIT) begin
         n = 2'd2;
      end
      return n;
   endfunction : instLen

   // Only listed special function addresses hold storage
   function automatic logic occupied(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         `CCS_PORT0_LATCH, `CCS_STACK_POINTER, `CCS_DATA_POINTER_LOW,
         `CCS_DATA_POINTER_HIGH, `CCS_POWER_CONTROL, `CCS_TIMER_CONTROL,
         `CCS_TIMER_MODE_SELECT, `CCS_TIMER0_LOW_BYTE, `CCS_TIMER1_LOW_BYTE,
         `CCS_TIMER0_HIGH_BYTE, `CCS_TIMER1_HIGH_BYTE, `CCS_PORT1_LATCH,
         `CCS_PORT1_FUNCTION_SELECT, `CCS_PORT3_FUNCTION_SELECT,
         `CCS_PORT4_FUNCTION_SELECT, `CCS_ADC_CLOCK_PRESCALER, `CCS_ADC_RESULT,
         `CCS_ADC_CONTROL_STATUS, `CCS_UART0_CONTROL, `CCS_UART0_BUFFER,
         `CCS_UART1_CONTROL, `CCS_UART1_BUFFER, `CCS_PORT2_LATCH,
         `CCS_STATUS_WORD, `CCS_ACCUMULATOR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : occupied

   // Holes read as zero; the converter result is read-only to software
   function automatic logic [7:0] rdDir(input ccs_pkg::ccs_state_t s, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (!a[7]) begin
         v = s.ram[a[6:0]];
      end else if (occupied(a)) begin
         v = s.sfr[a[6:0]];
      end
      return v;
   endfunction : rdDir

   function automatic ccs_pkg::ccs_state_t wrDir(input ccs_pkg::ccs_state_t s,
                                                 input logic [7:0] a, input logic [7:0] v);
      ccs_pkg::ccs_state_t r;
      r = s;
      if (!a[7]) begin
         r.ram[a[6:0]] = v;
      end else if (occupied(a) && a != `CCS_ADC_RESULT) begin
         r.sfr[a[6:0]] = v;
      end
      return r;
   endfunction : wrDir

   // Bit space: low half in bit RAM, high half at row-start registers
   function automatic ccs_pkg::ccs_state_t wrBit(input ccs_pkg::ccs_state_t s,
                                                 input logic [7:0] b, input logic v);
      ccs_pkg::ccs_state_t r;
      logic [7:0] a;
      logic [7:0] d;
      r = s;
      a = b[7] ? {b[7:3], 3'b000} : {1'b0, `CCS_BIT_RAM_BASE + {3'b000, b[6:3]}};
      d = rdDir(s, a);
      d[b[2:0]] = v;
      r = wrDir(r, a, d);
      return r;
   endfunction : wrBit

   function automatic ccs_pkg::ccs_state_t rstState();
      ccs_pkg::ccs_state_t s;
      s = '0;
      s.st = ccs_pkg::S1;
      s.run = RUN_AT_RESET;
      s.sfr[sfrSlot(`CCS_PORT0_LATCH)] = `CCS_PORT_RESET;
      s.sfr[sfrSlot(`CCS_PORT1_LATCH)] = `CCS_PORT_RESET;
      s.sfr[sfrSlot(`CCS_PORT2_LATCH)] = `CCS_PORT_RESET;
      s.sfr[sfrSlot(`CCS_STACK_POINTER)] = `CCS_STACK_RESET;
      return s;
   endfunction : rstState

   assign apbIdx = paddr[9:2];
   assign apbErr = (paddr[11:10] != 2'b00) ||
                   (apbIdx > `CCS_IDX_STATUS && apbIdx < `CCS_IDX_SFR_FIRST);
   assign pready = psel && penable && cur_ff.apbDone;
   assign pslverr = pready && apbErr;
   assign prdata = cur_ff.prdata;
   assign memAddr = cur_ff.memAddr;
   assign memDataOut = cur_ff.memDataOut;
   assign memResetN = cur_ff.memResetN;

   // Second cycle of a data move: data strobes instead of program fetches
   assign movxCyc = cur_ff.cyc2 && isMovx(cur_ff.op);
   assign addrLatch = !cur_ff.ph &&
                      (cur_ff.st == ccs_pkg::S1 || (cur_ff.st == ccs_pkg::S4 && !movxCyc));
   assign progStoreStrobeN = !(cur_ff.ph && !movxCyc &&
                               (cur_ff.st == ccs_pkg::S1 || cur_ff.st == ccs_pkg::S4));
   assign memReadN = !(movxCyc && cur_ff.op == `CCS_OP_XMOVE_RD &&
                       (cur_ff.st == ccs_pkg::S2 || cur_ff.st == ccs_pkg::S3));
   assign memWriteN = !(movxCyc && cur_ff.op == `CCS_OP_XMOVE_WR &&
                        (cur_ff.st == ccs_pkg::S2 || cur_ff.st == ccs_pkg::S3));

   always_comb begin
      logic adv;
      logic last;
      logic take;
      logic [7:0] acc;
      logic [7:0] rel;
      logic [7:0] dec;
      logic [1:0] len;
      nxt_cur = cur_ff;
      adv = 1'b0;
      last = 1'b0;
      take = 1'b0;
      acc = cur_ff.sfr[sfrSlot(`CCS_ACCUMULATOR)];
      len = instLen(cur_ff.op);
      rel = (len == 2'd3) ? cur_ff.b3 : cur_ff.b2;
      dec = 8'h00;
      nxt_cur.memResetN = 1'b1;

      // Register bus: data captured in the first access cycle, answered in the next
      if (psel && penable && !cur_ff.apbDone) begin
         nxt_cur.apbDone = 1'b1;
         if (apbIdx == `CCS_IDX_CTRL) begin
            nxt_cur.prdata = {31'h0000_0000, cur_ff.run};
         end else if (apbIdx == `CCS_IDX_STATUS) begin
            nxt_cur.prdata = {11'h000, cur_ff.cyc2, cur_ff.ph, 3'(cur_ff.st), cur_ff.pc};
         end else if (!apbErr) begin
            nxt_cur.prdata = {24'h00_0000, rdDir(cur_ff, apbIdx)};
         end else begin
            nxt_cur.prdata = 32'h0000_0000;
         end
      end
      if (pready) begin
         nxt_cur.apbDone = 1'b0;
         if (pwrite && pstrb[0] && !apbErr) begin
            if (apbIdx == `CCS_IDX_CTRL) begin
               nxt_cur.run = pwdata[0];
            end else if (apbIdx >= `CCS_IDX_SFR_FIRST) begin
               nxt_cur = wrDir(nxt_cur, apbIdx, pwdata[7:0]);
            end
         end
      end

      // Halt only at a machine cycle boundary
      adv = cur_ff.run || cur_ff.st != ccs_pkg::S1 || cur_ff.ph;
      if (adv) begin
         nxt_cur.ph = !cur_ff.ph;
         if (cur_ff.ph) begin
            unique case (cur_ff.st)
               ccs_pkg::S1: nxt_cur.st = ccs_pkg::S2;
               ccs_pkg::S2: nxt_cur.st = ccs_pkg::S3;
               ccs_pkg::S3: nxt_cur.st = ccs_pkg::S4;
               ccs_pkg::S4: nxt_cur.st = ccs_pkg::S5;
               ccs_pkg::S5: nxt_cur.st = ccs_pkg::S6;
               ccs_pkg::S6: nxt_cur.st = ccs_pkg::S1;
            endcase
         end
      end

      if (adv && cur_ff.ph) begin
         // Byte arrives at the end of the fetch half
         if (cur_ff.st == ccs_pkg::S1 && !cur_ff.cyc2) begin
            nxt_cur.op = memDataIn;
            nxt_cur.pc = cur_ff.pc + 16'h0001;
         end else if (cur_ff.st == ccs_pkg::S1 && !movxCyc && len == 2'd3) begin
            nxt_cur.b3 = memDataIn;
            nxt_cur.pc = cur_ff.pc + 16'h0001;
         end
         if (cur_ff.st == ccs_pkg::S4 && !cur_ff.cyc2 && len != 2'd1) begin
            nxt_cur.b2 = memDataIn;
            nxt_cur.pc = cur_ff.pc + 16'h0001;
         end // Otherwise the fetched byte is dropped and the counter held
         if (cur_ff.st == ccs_pkg::S3 && movxCyc && cur_ff.op == `CCS_OP_XMOVE_RD) begin
            nxt_cur.b3 = memDataIn;
         end
         if (cur_ff.st == ccs_pkg::S6) begin
            last = cur_ff.cyc2 || (!isMovx(cur_ff.op) && len != 2'd3);
            nxt_cur.cyc2 = !last;
         end
      end

      // Execution completes at the end of S6 of the final cycle
      if (last) begin
         if (cur_ff.op[7:3] == `CCS_OP_DEC_REG_HI) begin
            dec = cur_ff.ram[{4'h0, cur_ff.op[2:0]}] - 8'h01;
            nxt_cur.ram[{4'h0, cur_ff.op[2:0]}] = dec;
            take = (dec != 8'h00);
         end else begin
            case (cur_ff.op)
               `CCS_OP_SHORT_JUMP: take = 1'b1;
               `CCS_OP_ACC_ZERO: take = (acc == 8'h00);
               `CCS_OP_ACC_NONZERO: take = (acc != 8'h00);
               `CCS_OP_DEC_DIRECT: begin
                  dec = rdDir(nxt_cur, cur_ff.b2) - 8'h01;
                  nxt_cur = wrDir(nxt_cur, cur_ff.b2, dec);
                  take = (dec != 8'h00);
               end
               `CCS_OP_CMP_IMM: begin
                  take = (acc != cur_ff.b2);
                  nxt_cur.sfr[sfrSlot(`CCS_STATUS_WORD)][`CCS_CARRY_BIT] =
                     (acc < cur_ff.b2);
               end
               `CCS_OP_LOAD_ACC: nxt_cur = wrDir(nxt_cur, `CCS_ACCUMULATOR, cur_ff.b2);
               `CCS_OP_STORE_DIRECT: nxt_cur = wrDir(nxt_cur, cur_ff.b2, acc);
               `CCS_OP_SET_BIT: nxt_cur = wrBit(nxt_cur, cur_ff.b2, 1'b1);
               `CCS_OP_CLEAR_BIT: nxt_cur = wrBit(nxt_cur, cur_ff.b2, 1'b0);
               `CCS_OP_XMOVE_RD: nxt_cur = wrDir(nxt_cur, `CCS_ACCUMULATOR, cur_ff.b3);
               default: take = 1'b0;
            endcase
         end
         if (take) begin
            nxt_cur.pc = nxt_cur.pc + {{8{rel[7]}}, rel};
         end
      end

      // Address bus set up for the half that raises the latch strobe
      if (adv && cur_ff.ph && (cur_ff.st == ccs_pkg::S6 || cur_ff.st == ccs_pkg::S3)) begin
         if (nxt_cur.cyc2 && isMovx(nxt_cur.op)) begin
            nxt_cur.memAddr = {nxt_cur.sfr[sfrSlot(`CCS_DATA_POINTER_HIGH)],
                               nxt_cur.sfr[sfrSlot(`CCS_DATA_POINTER_LOW)]};
            nxt_cur.memDataOut = nxt_cur.sfr[sfrSlot(`CCS_ACCUMULATOR)];
         end else begin
            nxt_cur.memAddr = nxt_cur.pc;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_ff <= rstState();
      end else begin
         cur_ff <= nxt_cur;
      end
   end
endmodule : ccs_core_sequencer

// [ccs_core_sequencer_properties.sv]
// Concurrent checks on the ports of the core cycle sequencer
module ccs_core_sequencer_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] memAddr,
   input wire logic memReadN,
   input wire logic memWriteN,
   input wire logic progStoreStrobeN,
   input wire logic addrLatch,
   input wire logic memResetN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_CYCLE_SPAN: assert property (addrLatch |-> (##6 addrLatch) or (##12 addrLatch))
      else $error("address latch spacing wrong");
   AST_LATCH_ONE_HALF: assert property (addrLatch |=> !addrLatch [*5])
      else $error("address latch longer than one half");
   AST_FETCH_AFTER_LATCH: assert property (!progStoreStrobeN |-> $past(addrLatch) && $stable(memAddr))
      else $error("fetch strobe not in second half");
   AST_FETCH_OR_MOVE: assert property (addrLatch |=> (!progStoreStrobeN) or (##1 !(memReadN && memWriteN)))
      else $error("program fetch omitted");
   AST_MOVE_READ_SPAN: assert property ($fell(memReadN) |-> !memReadN [*4] ##1 memReadN)
      else $error("data move read window wrong");
   AST_MOVE_NO_FETCH: assert property ((!memReadN || !memWriteN) |-> progStoreStrobeN && !addrLatch && (memReadN || memWriteN) && $stable(memAddr))
      else $error("fetch during data move");
   AST_MOVE_TAIL: assert property ($rose(memWriteN) |-> progStoreStrobeN [*6])
      else $error("fetch in second cycle of data move");
   AST_MEM_RESET: assert property (!$past(rst) |-> memResetN)
      else $error("memory reset still low");
   AST_FIRST_FETCH: assert property ($past(rst) |-> addrLatch && memAddr == 16'h0000 ##1 !progStoreStrobeN && memAddr == 16'h0000)
      else $error("first fetch not at address zero");
   AST_HOLE_ERROR: assert property (pready && paddr[9:2] > 8'h01 && paddr[9:2] < 8'h80 |-> pslverr)
      else $error("unmapped access without error");
   AST_APB_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("bus answer not in second access cycle");
   COV_MOVE_READ: cover property ($fell(memReadN));
   COV_MOVE_WRITE: cover property ($fell(memWriteN));
   COV_BUS_ERROR: cover property (pready && pslverr);
   COV_BUS_WRITE: cover property (pready && pwrite);
endmodule : ccs_core_sequencer_properties

bind ccs_core_sequencer ccs_core_sequencer_properties u_props (
   .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .memAddr(memAddr), .memReadN(memReadN),
   .memWriteN(memWriteN), .progStoreStrobeN(progStoreStrobeN), .addrLatch(addrLatch),
   .memResetN(memResetN)
);

// [ccs_mem_model.sv]
// Behavioural program and data memory facing the sequencer
module ccs_mem_model (
   input wire logic clk,
   input wire logic [15:0] memAddr,
   input wire logic [7:0] memDataOut,
   output logic [7:0] memDataIn,
   input wire logic memReadN,
   input wire logic memWriteN,
   input wire logic progStoreStrobeN,
   input wire logic memResetN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rom [256];
   logic [7:0] ram [256];
   logic [7:0] idle_ff = 8'h00;
   // Idle bus toggles so a late sample never looks valid
   always_comb begin
      if (!progStoreStrobeN) begin
         memDataIn = rom[memAddr[7:0]];
      end else if (!memReadN) begin
         memDataIn = ram[memAddr[7:0]];
      end else begin
         memDataIn = ~idle_ff;
      end
   end
   always @(posedge clk) begin
      idle_ff <= memDataIn;
      if (!memWriteN && memResetN) begin
         ram[memAddr[7:0]] <= memDataOut;
      end
   end
endmodule : ccs_mem_model

// [test_core_cycle_sequencer_sfr_space.sv]
// Self-checking bench for the core cycle sequencer
module test_core_cycle_sequencer_sfr_space;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [11:0] addr;
      logic wr;
      logic [3:0] strb;
      logic [31:0] data;
      logic err;
   } ccs_row_t;
   localparam ccs_row_t ROWS [20] = '{
      '{12'h200, 1'b0, 4'hf, 32'h0000_00ff, 1'b0}, '{12'h204, 1'b0, 4'hf, 32'h0000_0007, 1'b0},
      '{12'h20c, 1'b0, 4'hf, 32'h0000_0000, 1'b0}, '{12'h21c, 1'b0, 4'hf, 32'h0000_0000, 1'b0},
      '{12'h240, 1'b0, 4'hf, 32'h0000_00ff, 1'b0}, '{12'h280, 1'b0, 4'hf, 32'h0000_00ff, 1'b0},
      '{12'h204, 1'b1, 4'hf, 32'h0000_005a, 1'b0}, '{12'h204, 1'b0, 4'hf, 32'h0000_005a, 1'b0},
      '{12'h204, 1'b1, 4'h0, 32'h0000_0033, 1'b0}, '{12'h204, 1'b0, 4'hf, 32'h0000_005a, 1'b0},
      '{12'h210, 1'b1, 4'hf, 32'h0000_005a, 1'b0}, '{12'h210, 1'b0, 4'hf, 32'h0000_0000, 1'b0},
      '{12'h210, 1'b1, 4'hf, 32'h0000_0000, 1'b0}, '{12'h258, 1'b1, 4'hf, 32'h0000_0033, 1'b0},
      '{12'h258, 1'b0, 4'hf, 32'h0000_0000, 1'b0}, '{12'h260, 1'b1, 4'hf, 32'h0000_00c3, 1'b0},
      '{12'h260, 1'b0, 4'hf, 32'h0000_00c3, 1'b0}, '{12'h008, 1'b1, 4'hf, 32'h0000_0011, 1'b1},
      '{12'he00, 1'b0, 4'hf, 32'h0000_0000, 1'b1}, '{12'h000, 1'b0, 4'hf, 32'h0000_0001, 1'b0}};
   localparam logic [7:0] PROG [26] = '{8'h74, 8'h02, 8'hf5, 8'h00, 8'hd8, 8'hfe, 8'hf5, 8'h82,
      8'hf0, 8'h74, 8'h00, 8'he0, 8'h60, 8'h10, 8'h70, 8'h01, 8'h00, 8'hb4, 8'h05, 8'h02,
      8'h00, 8'h00, 8'hd2, 8'h8b, 8'h80, 8'hfe};
   localparam logic [7:0] TRACE [30] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h04,
      8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0c, 8'h0d, 8'h0e,
      8'h0f, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h18, 8'h19};
   logic clk = 1'b0;
   logic rst, psel, penable, pwrite, pready, pslverr, memReadN, memWriteN;
   logic progStoreStrobeN, addrLatch, memResetN, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [15:0] memAddr, xWrAddr, xRdAddr;
   logic [7:0] memDataOut, memDataIn, xWrData;
   logic [15:0] fetches [$];
   int fails = 0;
   int samplesChecked = 0;
   ccs_core_sequencer dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .memAddr(memAddr), .memDataOut(memDataOut), .memDataIn(memDataIn),
      .memReadN(memReadN), .memWriteN(memWriteN), .progStoreStrobeN(progStoreStrobeN),
      .addrLatch(addrLatch), .memResetN(memResetN));
   ccs_mem_model mem (.clk(clk), .memAddr(memAddr), .memDataOut(memDataOut),
      .memDataIn(memDataIn), .memReadN(memReadN), .memWriteN(memWriteN),
      .progStoreStrobeN(progStoreStrobeN), .memResetN(memResetN));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (!rst && progStoreStrobeN === 1'b0) fetches.push_back(memAddr);
      if (memWriteN === 1'b0) begin
         xWrAddr = memAddr;
         xWrData = memDataOut;
      end
      if (memReadN === 1'b0) xRdAddr = memAddr;
   end
   task automatic give_verdict();
      if (fails == 0 && samplesChecked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_bit(input string what, input logic exp, input logic got);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic apb(input logic [11:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pstrb <= s;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_fetches(input int cnt);
      for (int n = 0; n < 3000 && fetches.size() < cnt; n++) @(posedge clk);
      if (fetches.size() < cnt) fails++;
   endtask : wait_fetches
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      for (int i = 0; i < 256; i++) begin
         mem.rom[i] = (i < 26) ? PROG[i] : 8'h00;
         mem.ram[i] = 8'h00;
      end
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         apb(ROWS[i].addr, ROWS[i].wr, ROWS[i].strb, ROWS[i].data, rd, er);
         chk_bit("pslverr", ROWS[i].err, er);
         if (!ROWS[i].wr) chk_word("prdata", ROWS[i].data, rd);
      end
      wait_fetches(30);
      foreach (TRACE[i]) chk_word("fetch address", {24'h00_0000, TRACE[i]}, {16'h0000, fetches[i]});
      chk_word("move write address", 32'h0000_0002, {16'h0000, xWrAddr});
      chk_word("move write data", 32'h0000_0002, {24'h00_0000, xWrData});
      chk_word("move read address", 32'h0000_0002, {16'h0000, xRdAddr});
      apb(12'h380, 1'b0, 4'hf, 32'h0000_0000, rd, er);
      chk_word("accumulator", 32'h0000_0002, rd);
      apb(12'h340, 1'b0, 4'hf, 32'h0000_0000, rd, er);
      chk_bit("carry", 1'b1, rd[7]);
      apb(12'h208, 1'b0, 4'hf, 32'h0000_0000, rd, er);
      chk_word("data pointer low", 32'h0000_0002, rd);
      apb(12'h220, 1'b0, 4'hf, 32'h0000_0000, rd, er);
      chk_word("timer control", 32'h0000_0008, rd);
      fetches.delete();
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      chk_bit("memory reset", 1'b0, memResetN);
      rst <= 1'b0;
      wait_fetches(2);
      chk_bit("memory reset", 1'b1, memResetN);
      chk_word("first fetch", 32'h0000_0000, {16'h0000, fetches[0]});
      chk_word("second fetch", 32'h0000_0001, {16'h0000, fetches[1]});
      apb(12'h204, 1'b0, 4'hf, 32'h0000_0000, rd, er);
      chk_word("stack pointer", 32'h0000_0007, rd);
      give_verdict();
   end
endmodule : test_core_cycle_sequencer_sfr_space
